// ### lgp_pkg.sv
// Overview of operation
// - data line changes only while serial clock is low, stable while high
// - data falling while clock high is detected as START
// - data rising while clock high is detected as STOP
// - bus busy from START until STOP, idle after STOP
// - repeated START behaves exactly like a first START
// - bytes are eight bits, most significant first, then one acknowledge slot
// - the byte sender releases the data line during the acknowledge pulse
// - addressed receiver pulls data low on the ninth pulse of each byte
// - first byte holds seven-bit address; respond only to 59H
// - direction bit 0 means write, 1 means read
// - write: second byte is register index, third byte is the value
// - written value takes effect at clock rise of last device acknowledge
// - three bidirectional pins; pin 0 may serve as external PWM input
// - control register 06H bits 2:0 set pin direction, 1 is output
// - control bit 4 enables the PWM input function of pin 0
// - with PWM enabled pin 0 is an input whatever its direction bit
// - pins 1 and 2 follow only their direction bits
// - data register 07H bits 2:0 give the level of output pins
// - reading the data register returns actual pin levels
package lgp_pkg;

  localparam logic [6:0] DEV_ADDR = 7'h59;
  localparam logic DIR_READ = 1'b1;
  localparam logic [7:0] CTRL_OFS = 8'h06;
  localparam logic [7:0] DATA_OFS = 8'h07;
  localparam int PWM_BIT = 4;
  localparam logic [7:0] CTRL_MASK = 8'h17;
  localparam logic [7:0] DATA_MASK = 8'h07;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [5:0] SYNC_IDLE = 6'h3f;

  // output data hold after the falling clock edge
  localparam int CLK_PERIOD_NS = 40;
  localparam int HOLD_NS = 300;
  localparam logic [3:0] HOLD_CYC =
    4'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_INDEX, ST_INDEX_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK, ST_IGNORE
  } lgp_state_t;

  // synchroniser bits: {ext_rst_n, gpio[2:0], sda, scl}
  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic scl_d;
    logic sda_d;
  } lgp_sync_t;

  typedef struct packed {
    lgp_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] index;
    logic rw;
    logic ack_ok;
    logic [7:0] ctrl;
    logic [7:0] data;
    logic want_low;
    logic [3:0] hold_cnt;
    logic sda_oe_n;
    logic sda_o;
    logic busy;
    logic [2:0] gpio_out;
    logic [2:0] gpio_oe_n;
    logic pwm_level;
  } lgp_core_t;

  localparam lgp_core_t CORE_RST = '{
    state: ST_IDLE, bit_cnt: 4'h0, shreg: 8'h00, index: 8'h00,
    rw: 1'b0, ack_ok: 1'b0, ctrl: CTRL_RST, data: DATA_RST,
    want_low: 1'b0, hold_cnt: 4'h0, sda_oe_n: 1'b1, sda_o: 1'b0,
    busy: 1'b0, gpio_out: 3'h0, gpio_oe_n: 3'h7, pwm_level: 1'b0
  };

endpackage

// ### lgp_line_if.sv
`timescale 1ns/1ps
interface lgp_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic ext_rst;
  logic [2:0] pins;
  modport src (
    output scl, sda, scl_rise, scl_fall, start, stop, ext_rst, pins
  );
  modport snk (
    input scl, sda, scl_rise, scl_fall, start, stop, ext_rst, pins
  );
endinterface

// ### lgp_line_sync.sv
`timescale 1ns/1ps
module lgp_line_sync (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // raw pins
  input wire logic scl_pin,
  input wire logic sda_pin,
  input wire logic [2:0] gpio_pin,
  input wire logic external_reset_n,
  // synchronised view
  lgp_line_if.src line
);

  lgp_pkg::lgp_sync_t r;
  lgp_pkg::lgp_sync_t r_nxt;

  always_comb begin
    r_nxt = r;
    r_nxt.s1 = {external_reset_n, gpio_pin, sda_pin, scl_pin};
    r_nxt.s2 = r.s1;
    r_nxt.scl_d = r.s2[0];
    r_nxt.sda_d = r.s2[1];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r <= '{s1: lgp_pkg::SYNC_IDLE, s2: lgp_pkg::SYNC_IDLE,
             scl_d: 1'b1, sda_d: 1'b1};
    end else if (clk_en) begin
      r <= r_nxt;
    end
  end

  // edges only from second stage onward, never the first flop
  assign line.scl = r.s2[0];
  assign line.sda = r.s2[1];
  assign line.pins = r.s2[4:2];
  assign line.ext_rst = ~r.s2[5];
  assign line.scl_rise = r.s2[0] & ~r.scl_d;
  assign line.scl_fall = ~r.s2[0] & r.scl_d;
  assign line.start = r.scl_d & r.s2[0] & r.sda_d & ~r.s2[1];
  assign line.stop = r.scl_d & r.s2[0] & ~r.sda_d & r.s2[1];

endmodule

// ### lgp_reg_port.sv
`timescale 1ns/1ps
module lgp_reg_port (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic external_reset_n,
  // serial bus
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic sda_out,
  output logic sda_oe_n,
  // general-purpose pins
  input wire logic [2:0] gpio_pin,
  output logic [2:0] gpio_out,
  output logic [2:0] gpio_oe_n,
  // status toward the led drivers
  output logic pwm_level,
  output logic bus_busy
);

  lgp_line_if line ();

  lgp_line_sync u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .scl_pin(scl_pin),
    .sda_pin(sda_pin),
    .gpio_pin(gpio_pin),
    .external_reset_n(external_reset_n),
    .line(line)
  );

  lgp_pkg::lgp_core_t r;
  lgp_pkg::lgp_core_t r_nxt;

  // unmapped indexes read as zero
  function automatic logic [7:0] rd_value(input logic [7:0] idx,
                                          input logic [7:0] ctrl,
                                          input logic [2:0] pins);
    rd_value = 8'h00;
    if (idx == lgp_pkg::CTRL_OFS) begin
      rd_value = ctrl & lgp_pkg::CTRL_MASK;
    end else if (idx == lgp_pkg::DATA_OFS) begin
      rd_value = {5'h00, pins};
    end
  endfunction

  always_comb begin
    logic [7:0] rd;
    rd = rd_value(r.index, r.ctrl, line.pins);
    r_nxt = r;
    r_nxt.sda_o = 1'b0;
    // drive changes wait out the hold time after the clock fell
    if (r.hold_cnt != 4'h0) begin
      r_nxt.hold_cnt = r.hold_cnt - 4'h1;
      if (r.hold_cnt == 4'h1) begin
        r_nxt.sda_oe_n = ~r.want_low;
      end
    end
    if (line.stop) begin
      r_nxt.state = lgp_pkg::ST_IDLE;
      r_nxt.busy = 1'b0;
      r_nxt.want_low = 1'b0;
      r_nxt.hold_cnt = 4'h0;
      r_nxt.sda_oe_n = 1'b1;
    end else if (line.start) begin
      r_nxt.state = lgp_pkg::ST_ADDR;
      r_nxt.bit_cnt = 4'h0;
      r_nxt.busy = 1'b1;
      r_nxt.want_low = 1'b0;
      r_nxt.hold_cnt = 4'h0;
      r_nxt.sda_oe_n = 1'b1;
    end else if (line.scl_rise) begin
      unique case (r.state)
        lgp_pkg::ST_ADDR, lgp_pkg::ST_INDEX, lgp_pkg::ST_WDATA: begin
          if (r.bit_cnt != lgp_pkg::BYTE_BITS) begin
            r_nxt.shreg = {r.shreg[6:0], line.sda};
            r_nxt.bit_cnt = r.bit_cnt + 4'h1;
          end
        end
        lgp_pkg::ST_WDATA_ACK: begin
          if (r.index == lgp_pkg::CTRL_OFS) begin
            r_nxt.ctrl = r.shreg & lgp_pkg::CTRL_MASK;
          end else if (r.index == lgp_pkg::DATA_OFS) begin
            r_nxt.data = r.shreg & lgp_pkg::DATA_MASK;
          end
        end
        lgp_pkg::ST_RDATA_ACK: begin
          r_nxt.ack_ok = ~line.sda;
        end
        lgp_pkg::ST_IDLE, lgp_pkg::ST_ADDR_ACK, lgp_pkg::ST_INDEX_ACK,
        lgp_pkg::ST_RDATA, lgp_pkg::ST_IGNORE: begin
        end
      endcase
    end else if (line.scl_fall) begin
      r_nxt.hold_cnt = lgp_pkg::HOLD_CYC;
      unique case (r.state)
        lgp_pkg::ST_ADDR: begin
          if (r.bit_cnt == lgp_pkg::BYTE_BITS) begin
            if (r.shreg[7:1] == lgp_pkg::DEV_ADDR) begin
              r_nxt.state = lgp_pkg::ST_ADDR_ACK;
              r_nxt.rw = r.shreg[0];
              r_nxt.want_low = 1'b1;
            end else begin
              r_nxt.state = lgp_pkg::ST_IGNORE;
              r_nxt.want_low = 1'b0;
            end
          end
        end
        lgp_pkg::ST_INDEX: begin
          if (r.bit_cnt == lgp_pkg::BYTE_BITS) begin
            r_nxt.index = r.shreg;
            r_nxt.state = lgp_pkg::ST_INDEX_ACK;
            r_nxt.want_low = 1'b1;
          end
        end
        lgp_pkg::ST_WDATA: begin
          if (r.bit_cnt == lgp_pkg::BYTE_BITS) begin
            r_nxt.state = lgp_pkg::ST_WDATA_ACK;
            r_nxt.want_low = 1'b1;
          end
        end
        lgp_pkg::ST_ADDR_ACK: begin
          r_nxt.bit_cnt = 4'h0;
          if (r.rw == lgp_pkg::DIR_READ) begin
            r_nxt.state = lgp_pkg::ST_RDATA;
            r_nxt.shreg = rd;
            r_nxt.want_low = ~rd[7];
          end else begin
            r_nxt.state = lgp_pkg::ST_INDEX;
            r_nxt.want_low = 1'b0;
          end
        end
        lgp_pkg::ST_INDEX_ACK, lgp_pkg::ST_WDATA_ACK: begin
          // further bytes rewrite the same index
          r_nxt.state = lgp_pkg::ST_WDATA;
          r_nxt.bit_cnt = 4'h0;
          r_nxt.want_low = 1'b0;
        end
        lgp_pkg::ST_RDATA: begin
          if (r.bit_cnt == 4'h7) begin
            r_nxt.state = lgp_pkg::ST_RDATA_ACK;
            r_nxt.want_low = 1'b0;
          end else begin
            r_nxt.shreg = {r.shreg[6:0], 1'b0};
            r_nxt.want_low = ~r.shreg[6];
            r_nxt.bit_cnt = r.bit_cnt + 4'h1;
          end
        end
        lgp_pkg::ST_RDATA_ACK: begin
          r_nxt.bit_cnt = 4'h0;
          if (r.ack_ok) begin
            r_nxt.state = lgp_pkg::ST_RDATA;
            r_nxt.shreg = rd;
            r_nxt.want_low = ~rd[7];
          end else begin
            r_nxt.state = lgp_pkg::ST_IGNORE;
            r_nxt.want_low = 1'b0;
          end
        end
        lgp_pkg::ST_IDLE, lgp_pkg::ST_IGNORE: begin
          r_nxt.want_low = 1'b0;
        end
      endcase
    end
    // pin drivers follow the registers one cycle later
    for (int i = 0; i < 3; i++) begin
      r_nxt.gpio_oe_n[i] = ~r.ctrl[i];
      r_nxt.gpio_out[i] = r.data[i];
    end
    if (r.ctrl[lgp_pkg::PWM_BIT]) begin
      r_nxt.gpio_oe_n[0] = 1'b1;
    end
    r_nxt.pwm_level = r.ctrl[lgp_pkg::PWM_BIT] & line.pins[0];
    if (line.ext_rst) begin
      r_nxt = lgp_pkg::CORE_RST;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r <= lgp_pkg::CORE_RST;
    end else if (clk_en) begin
      r <= r_nxt;
    end
  end

  assign sda_out = r.sda_o;
  assign sda_oe_n = r.sda_oe_n;
  assign gpio_out = r.gpio_out;
  assign gpio_oe_n = r.gpio_oe_n;
  assign pwm_level = r.pwm_level;
  assign bus_busy = r.busy;

  // frozen cycles do not count as edges
  default clocking cb @(posedge ref_clk iff clk_en);
  endclocking
  default disable iff (rst || line.ext_rst);

  a_start_addr: assert property (
    line.start && !line.stop |=> r.state == lgp_pkg::ST_ADDR
      && r.bit_cnt == 4'h0 && r.busy)
    else $error("start not taken");
  a_stop_idle: assert property (
    line.stop |=> r.state == lgp_pkg::ST_IDLE && !r.busy && r.sda_oe_n)
    else $error("stop not taken");
  a_busy_span: assert property (
    $fell(r.busy) |-> $past(line.stop))
    else $error("bus freed without stop");
  a_restart_equal: assert property (
    r.busy && line.start && !line.stop |=> r.state == lgp_pkg::ST_ADDR)
    else $error("repeated start not restarting");
  a_sda_quiet_high: assert property (
    $changed(r.sda_oe_n) && !$past(line.start || line.stop) |-> !line.scl)
    else $error("data changed while clock high");
  a_ack_driven: assert property (
    r.state == lgp_pkg::ST_ADDR_ACK && line.scl_rise |-> !r.sda_oe_n)
    else $error("acknowledge not driven");
  a_addr_match: assert property (
    r.state == lgp_pkg::ST_ADDR_ACK && $past(r.state) == lgp_pkg::ST_ADDR
      |-> $past(r.shreg[7:1]) == lgp_pkg::DEV_ADDR)
    else $error("acknowledged foreign address");
  a_write_commit: assert property (
    r.state == lgp_pkg::ST_WDATA_ACK && line.scl_rise && !line.start
      && r.index == lgp_pkg::DATA_OFS
      |=> r.data == ($past(r.shreg) & lgp_pkg::DATA_MASK)
      ##2 r.gpio_out == r.data[2:0])
    else $error("write not committed");
  a_pwm_input: assert property (
    r.ctrl[lgp_pkg::PWM_BIT] ##1 r.ctrl[lgp_pkg::PWM_BIT]
      |-> r.gpio_oe_n[0])
    else $error("pin 0 driven under pwm");
  a_dir_follow: assert property (
    $stable(r.ctrl[2:1]) |=> r.gpio_oe_n[2:1] == ~$past(r.ctrl[2:1]))
    else $error("pin direction mismatch");
  a_ignore_quiet: assert property (
    r.state == lgp_pkg::ST_IGNORE && r.hold_cnt == 4'h0 |-> r.sda_oe_n)
    else $error("data driven while ignoring");
  a_read_release: assert property (
    r.state == lgp_pkg::ST_RDATA_ACK && r.hold_cnt == 4'h0 |-> r.sda_oe_n)
    else $error("data held in master acknowledge");
  a_read_level: assert property (
    $past(r.state) == lgp_pkg::ST_ADDR_ACK && r.state == lgp_pkg::ST_RDATA
      && r.index == lgp_pkg::DATA_OFS
      |-> r.shreg == {5'h00, $past(line.pins)})
    else $error("pin levels not returned");

  // byte hand-over points; a slip here shifts every later bit
  a_index_take: assert property (
    r.state == lgp_pkg::ST_INDEX && line.scl_fall
      && r.bit_cnt == lgp_pkg::BYTE_BITS
      |=> r.index == $past(r.shreg) && r.state == lgp_pkg::ST_INDEX_ACK)
    else $error("register index not taken");
  a_dir_take: assert property (
    r.state == lgp_pkg::ST_ADDR && line.scl_fall
      && r.bit_cnt == lgp_pkg::BYTE_BITS
      && r.shreg[7:1] == lgp_pkg::DEV_ADDR
      |=> r.rw == $past(r.shreg[0]) && r.state == lgp_pkg::ST_ADDR_ACK)
    else $error("direction bit not taken");
  a_foreign_drop: assert property (
    r.state == lgp_pkg::ST_ADDR && line.scl_fall
      && r.bit_cnt == lgp_pkg::BYTE_BITS
      && r.shreg[7:1] != lgp_pkg::DEV_ADDR
      |=> r.state == lgp_pkg::ST_IGNORE && r.sda_oe_n)
    else $error("foreign address not dropped");
  a_ignore_hold: assert property (
    r.state == lgp_pkg::ST_IGNORE && !line.start && !line.stop
      |=> r.state == lgp_pkg::ST_IGNORE)
    else $error("ignore left without start");
  a_busy_start: assert property (
    $rose(r.busy) |-> $past(line.start))
    else $error("bus taken without start");
  a_commit_only_ack: assert property (
    !(r.state == lgp_pkg::ST_WDATA_ACK && line.scl_rise)
      |=> $stable(r.ctrl) && $stable(r.data))
    else $error("register changed outside acknowledge");
  a_byte_ack_low: assert property (
    (r.state == lgp_pkg::ST_INDEX_ACK || r.state == lgp_pkg::ST_WDATA_ACK)
      && line.scl_rise |-> !r.sda_oe_n)
    else $error("byte acknowledge not driven");
  a_master_ack_free: assert property (
    r.state == lgp_pkg::ST_RDATA_ACK && line.scl_rise |-> r.sda_oe_n)
    else $error("data held in master acknowledge pulse");
  a_first_rbit: assert property (
    r.state == lgp_pkg::ST_RDATA && $past(r.state) == lgp_pkg::ST_ADDR_ACK
      |-> r.want_low == !r.shreg[7])
    else $error("first read bit wrong");
  a_pwm_off_low: assert property (
    !r.ctrl[lgp_pkg::PWM_BIT] |=> !r.pwm_level)
    else $error("pwm level while disabled");
  a_pwm_follow: assert property (
    r.ctrl[lgp_pkg::PWM_BIT] |=> r.pwm_level == $past(line.pins[0]))
    else $error("pwm level not following pin");
  a_out_follow: assert property (
    r.gpio_out == $past(r.data[2:0]))
    else $error("pin level not following data");

  c_write_done: cover property (
    r.state == lgp_pkg::ST_WDATA_ACK && line.scl_rise);
  c_read_start: cover property (
    r.state == lgp_pkg::ST_ADDR_ACK ##1 r.state == lgp_pkg::ST_RDATA);
  c_restart: cover property (r.busy && line.start);
  c_foreign: cover property (r.state == lgp_pkg::ST_IGNORE);
  c_read_again: cover property (
    r.state == lgp_pkg::ST_RDATA_ACK ##1 r.state == lgp_pkg::ST_RDATA);

endmodule

// ### lgp_bus_master.sv
`timescale 1ns/1ps
module lgp_bus_master (
  // clock
  input wire logic ref_clk,
  // device side of the data wire
  input wire logic sda_oe_n,
  input wire logic sda_out,
  // resolved wires
  output logic scl,
  output logic sda
);
  logic sda_rel;

  // pull-up: a released wire reads high
  assign sda = sda_rel & (sda_oe_n | sda_out);

  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // also serves as repeated start when entered with scl low
  task automatic start();
    wt(2);
    sda_rel = 1'b1;
    wt(14);
    scl = 1'b1;
    wt(8);
    sda_rel = 1'b0;
    wt(8);
    scl = 1'b0;
  endtask

  task automatic stop();
    wt(2);
    sda_rel = 1'b0;
    wt(14);
    scl = 1'b1;
    wt(8);
    sda_rel = 1'b1;
    wt(16);
  endtask

  // 640 ns low phase: device answer lands about 420 ns after the fall
  task automatic bit_io(input logic b, output logic r);
    wt(2);
    sda_rel = b;
    wt(14);
    scl = 1'b1;
    wt(4);
    r = sda;
    wt(4);
    scl = 1'b0;
  endtask

  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, ack);
  endtask

  task automatic get(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(ack, r);
  endtask
endmodule

// ### tb_lgp_reg_port.sv
`timescale 1ns/1ps
module tb_lgp_reg_port;
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] rv;
    logic [2:0] oe;
    logic [2:0] out;
  } lgp_row_t;

  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic ext_rst_n = 1'b1;
  logic [2:0] gpio_drv = 3'h0;
  logic scl, sda, sda_out, sda_oe_n, pwm_level, bus_busy, k;
  logic [2:0] gpio_pin, gpio_out, gpio_oe_n;
  logic [7:0] v, v2;
  int err_count = 0;
  int samples_checked = 0;
  // pin 1 reads low although the bench pulls it high: device wins
  lgp_row_t rows [4] = '{
    '{8'h06, 8'hff, 8'h17, 3'h1, 3'h0},
    '{8'h06, 8'h03, 8'h03, 3'h4, 3'h0},
    '{8'h07, 8'h05, 8'h01, 3'h4, 3'h5},
    '{8'h05, 8'haa, 8'h00, 3'h4, 3'h5}
  };

  always #20 ref_clk = ~ref_clk;

  assign gpio_pin = (gpio_oe_n & gpio_drv) | (~gpio_oe_n & gpio_out);

  lgp_bus_master m (
    .ref_clk(ref_clk), .sda_oe_n(sda_oe_n), .sda_out(sda_out),
    .scl(scl), .sda(sda)
  );

  lgp_reg_port uut (
    .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
    .external_reset_n(ext_rst_n), .scl_pin(scl), .sda_pin(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .gpio_pin(gpio_pin),
    .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
    .pwm_level(pwm_level), .bus_busy(bus_busy)
  );

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checked %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    m.start();
    m.put(8'hb2, k);
    chk1(k, 1'b0);
    m.put(i, k);
    chk1(k, 1'b0);
    m.put(d, k);
    chk1(k, 1'b0);
    m.stop();
  endtask

  // master acks the first byte, so the same register comes again
  task automatic rd(input logic [7:0] i, output logic [7:0] d,
    output logic [7:0] d2);
    m.start();
    m.put(8'hb2, k);
    m.put(i, k);
    m.start();
    m.put(8'hb3, k);
    chk1(k, 1'b0);
    m.get(1'b0, d);
    m.get(1'b1, d2);
    m.stop();
    chk1(sda_oe_n, 1'b1);
  endtask

  initial begin
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    m.wt(4);
    chk8({gpio_oe_n, gpio_out, sda_oe_n, bus_busy}, 8'he2);
    chk1(sda_out, 1'b0);
    gpio_drv = 3'h2;
    foreach (rows[n]) begin
      wr(rows[n].idx, rows[n].wd);
      chk8({5'h0, gpio_oe_n}, {5'h0, rows[n].oe});
      chk8({5'h0, gpio_out}, {5'h0, rows[n].out});
      rd(rows[n].idx, v, v2);
      chk8(v, rows[n].rv);
      chk8(v2, rows[n].rv);
    end
    // foreign address: no ack, following bytes ignored
    m.start();
    m.wt(4);
    chk1(bus_busy, 1'b1);
    m.put(8'hb4, k);
    chk1(k, 1'b1);
    m.put(8'h06, k);
    chk1(k, 1'b1);
    m.put(8'h00, k);
    m.stop();
    chk1(bus_busy, 1'b0);
    chk8({5'h0, gpio_oe_n}, 8'h04);
    // pwm input on pin 0 overrides its direction bit
    wr(8'h06, 8'h11);
    chk8({5'h0, gpio_oe_n}, 8'h07);
    gpio_drv = 3'h1;
    m.wt(8);
    chk1(pwm_level, 1'b1);
    gpio_drv = 3'h0;
    m.wt(8);
    chk1(pwm_level, 1'b0);
    // frozen clock enable: a pin change must not reach the output
    clk_en = 1'b0;
    gpio_drv = 3'h1;
    m.wt(8);
    chk1(pwm_level, 1'b0);
    clk_en = 1'b1;
    m.wt(8);
    chk1(pwm_level, 1'b1);
    gpio_drv = 3'h0;
    // pin reset returns the registers to their reset state
    wr(8'h06, 8'h07);
    ext_rst_n = 1'b0;
    m.wt(8);
    ext_rst_n = 1'b1;
    m.wt(8);
    chk8({5'h0, gpio_oe_n}, 8'h07);
    rd(8'h06, v, v2);
    chk8(v, 8'h00);
    chk8(v2, 8'h00);
    results();
  end

  // about 450 us of traffic expected
  initial begin
    #2000000;
    err_count++;
    results();
  end
endmodule
